// ---- inc/pulse_monitor_consts.svh ----
// Timing and layout constants for the test pulse and interlock monitor
`ifndef PULSE_MONITOR_CONSTS_SVH
`define PULSE_MONITOR_CONSTS_SVH
`define CLK_FREQ_KHZ 250000
`define PULSE_DUR_MS 2
`define PULSE_INT_MS 1000
`define PULSE_DEL_MS 40
`define PULSE_PHASE_MS 70
`define ILK_WIN_MS 200
`define ILK_CLR_MS 1000
`define MS_CNT_W 11
`define NUM_INPUTS 6
`define NUM_SUPPLIES 7
`define START_SLOT 6
`endif

// ---- inc/pulse_monitor_pkg.sv ----
// Types for the test pulse and interlock monitor
package pulse_monitor_pkg;
   typedef enum logic [1:0] {ILK_IDLE, ILK_WINDOW, ILK_BOTH_OFF, ILK_ALERT} ilk_state_e;
endpackage

// ---- inc/tick_if.sv ----
// Millisecond tick carrier between divider and monitor
`timescale 1ns/1ps
interface tick_if;
   logic msTick;
   modport src (output msTick);
   modport dst (input msTick);
endinterface

// ---- hw/ms_tick_gen.sv ----
// Millisecond enable divider
`timescale 1ns/1ps
`include "pulse_monitor_consts.svh"
module ms_tick_gen #(
   parameter int CYCLES_PER_MS = `CLK_FREQ_KHZ
) (
   input wire logic core_clk,
   input wire logic rst_n,
   tick_if.src tick
);
   initial begin
      if (CYCLES_PER_MS < 2) $error("CYCLES_PER_MS too small");
   end
   logic [31:0] divCnt_q;
   wire divWrap = (divCnt_q == 32'(CYCLES_PER_MS - 1));
   // Free-running divider
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) divCnt_q <= 32'h0;
      else divCnt_q <= divWrap ? 32'h0 : divCnt_q + 32'h1;
   end
   assign tick.msTick = divWrap;
endmodule

// ---- hw/input_test_pulse_interlock_monitor.sv ----
// Test pulse generation, cross-circuit check and interlock monitor
// Function
// - Test pulses are emitted periodically on every safety supply output and the start supply.
// - Each test pulse lasts 2 ms.
// - Pulses on one supply output start 1000 ms apart.
// - The return pulse must be seen on the channel within 40 ms of pulse start.
// - Pulses on different supply outputs are staggered by at least 70 ms.
// - Pulse testing runs only when the configuration enables it.
// - The same logic serves both channels of all six inputs and the start pair.
// - An alert is raised when the second input is still active 200 ms after the first dropped.
// - The alert is raised at once if the first input re-activates before the second drops.
// - The alert clears after both inputs are held deactivated for one second.
// - Both inputs dropping inside the window allow later re-energizing.
// - Interlock monitoring runs only when the configuration enables it.
// - Deactivation of a safety input forces the outputs de-energized.
`timescale 1ns/1ps
`include "pulse_monitor_consts.svh"
module input_test_pulse_interlock_monitor #(
   parameter int CYCLES_PER_MS = `CLK_FREQ_KHZ
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pulseTestEn,
   input wire logic interlockEn,
   input wire logic [5:0] channelAIn,
   input wire logic [5:0] channelBIn,
   input wire logic startSenseIn,
   input wire logic [5:0] inputActive,
   output logic [5:0] supplyOut,
   output logic startSupplyOut,
   output logic crossFault,
   output logic interlockAlert,
   output logic outputsPermit,
   output logic msTickOut
);
   localparam int NS = `NUM_SUPPLIES;
   localparam int W = `MS_CNT_W;
   localparam logic [W-1:0] DUR = W'(`PULSE_DUR_MS);
   localparam logic [W-1:0] INTV = W'(`PULSE_INT_MS);
   localparam logic [W-1:0] DEL = W'(`PULSE_DEL_MS);
   localparam logic [W-1:0] PHASE = W'(`PULSE_PHASE_MS);
   localparam logic [W-1:0] WIN = W'(`ILK_WIN_MS);
   localparam logic [W-1:0] CLR = W'(`ILK_CLR_MS);
   localparam logic [31:0] DUR_CYC = 32'(`PULSE_DUR_MS * CYCLES_PER_MS);
   localparam logic [31:0] INT_CYC = 32'(`PULSE_INT_MS * CYCLES_PER_MS);
   initial begin
      if (NS * `PULSE_PHASE_MS + `PULSE_DEL_MS > `PULSE_INT_MS) $error("slots do not fit");
      if (CYCLES_PER_MS < 4) $error("CYCLES_PER_MS shorter than pin settle time");
   end

   tick_if tk();
   ms_tick_gen #(.CYCLES_PER_MS(CYCLES_PER_MS)) uTick (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tk)
   );
   wire ms = tk.msTick;

   // Two-flop synchronisers for all sense pins and input states
   logic [18:0] syncA_q, syncB_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_q <= 19'h0;
         syncB_q <= 19'h0;
      end else begin
         syncA_q <= {inputActive, startSenseIn, channelBIn, channelAIn};
         syncB_q <= syncA_q;
      end
   end
   wire [5:0] chA = syncB_q[5:0];
   wire [5:0] chB = syncB_q[11:6];
   wire startSense = syncB_q[12];
   wire [5:0] actv = syncB_q[18:13];

   // Period counter in ms, shared by all slots
   logic [W-1:0] msCnt_q;
   wire periodEnd = (msCnt_q == INTV - W'(1));
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) msCnt_q <= '0;
      else if (ms) msCnt_q <= periodEnd ? '0 : msCnt_q + W'(1);
   end

   // Checks wait for the first ms tick; supplies and synchronisers read low out of reset
   logic armed_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) armed_q <= 1'b0;
      else if (ms) armed_q <= 1'b1;
   end

   // Per-supply pulse drive and return check; slot 6 is the start pair
   logic [NS-1:0] pulseOn, inWin, chanLowA, chanLowB, seenA_q, seenB_q, missA, missB;
   logic [NS-1:0] foreign;
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : gSlot
         localparam logic [W-1:0] OFS = W'(g) * PHASE;
         wire [W-1:0] rel = msCnt_q - OFS;
         assign pulseOn[g] = pulseTestEn && (msCnt_q >= OFS) && (rel < DUR);
         assign inWin[g] = pulseTestEn && (msCnt_q >= OFS) && (rel < DEL);
         if (g == `START_SLOT) begin : gStart
            assign chanLowA[g] = !startSense;
            assign chanLowB[g] = !startSense;
         end else begin : gIn
            assign chanLowA[g] = !chA[g];
            assign chanLowB[g] = !chB[g];
         end
         // Latch a seen pulse inside the window, reset on the ms tick that ends its first millisecond
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               seenA_q[g] <= 1'b0;
               seenB_q[g] <= 1'b0;
            end else if (ms && msCnt_q == OFS) begin
               seenA_q[g] <= 1'b0;
               seenB_q[g] <= 1'b0;
            end else if (inWin[g]) begin
               seenA_q[g] <= seenA_q[g] | chanLowA[g];
               seenB_q[g] <= seenB_q[g] | chanLowB[g];
            end
         end
         // Window closing without a seen pulse is a miss
         wire winEnd = armed_q && ms && pulseTestEn && (rel == DEL);
         assign missA[g] = winEnd && !seenA_q[g];
         assign missB[g] = winEnd && !seenB_q[g];
         // A channel dipping outside its own window while another supply is pulsing is a foreign pulse
         assign foreign[g] = armed_q && pulseTestEn && !inWin[g] && (chanLowA[g] || chanLowB[g])
            && (|pulseOn);
      end
   endgenerate

   // Supply outputs high except during their own test pulse
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         supplyOut <= 6'h0;
         startSupplyOut <= 1'b0;
      end else begin
         supplyOut <= ~pulseOn[5:0];
         startSupplyOut <= ~pulseOn[`START_SLOT];
      end
   end

   // Sticky cross-circuit fault, cleared only by reset
   wire faultEvt = |{missA, missB, foreign};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) crossFault <= 1'b0;
      else if (faultEvt) crossFault <= 1'b1;
   end

   // Interlock monitor on inputs 0 and 1
   pulse_monitor_pkg::ilk_state_e ilk_q, ilk_d;
   logic [W-1:0] ilkCnt_q;
   logic firstIs0_q;
   wire in0 = actv[0];
   wire in1 = actv[1];
   wire bothOff = !in0 && !in1;
   wire firstBack = firstIs0_q ? in0 : in1;
   wire winExp = ms && (ilkCnt_q == WIN - W'(1));
   wire clrDone = ms && (ilkCnt_q == CLR - W'(1));
   always_comb begin
      ilk_d = ilk_q;
      unique case (ilk_q)
         pulse_monitor_pkg::ILK_IDLE: begin
            if (interlockEn && (in0 ^ in1)) ilk_d = pulse_monitor_pkg::ILK_WINDOW;
            else if (interlockEn && bothOff) ilk_d = pulse_monitor_pkg::ILK_BOTH_OFF;
         end
         pulse_monitor_pkg::ILK_WINDOW: begin
            if (bothOff) ilk_d = pulse_monitor_pkg::ILK_BOTH_OFF;
            else if (firstBack) ilk_d = pulse_monitor_pkg::ILK_ALERT;
            else if (winExp) ilk_d = pulse_monitor_pkg::ILK_ALERT;
         end
         pulse_monitor_pkg::ILK_BOTH_OFF: begin
            if (!bothOff) ilk_d = pulse_monitor_pkg::ILK_IDLE;
         end
         pulse_monitor_pkg::ILK_ALERT: begin
            if (bothOff && clrDone) ilk_d = pulse_monitor_pkg::ILK_BOTH_OFF;
         end
      endcase
      if (!interlockEn) ilk_d = pulse_monitor_pkg::ILK_IDLE;
   end

   // Interlock state, ms timer and first-dropped memory
   wire timerRestart = (ilk_d != ilk_q) || (ilk_q == pulse_monitor_pkg::ILK_ALERT && !bothOff);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ilk_q <= pulse_monitor_pkg::ILK_IDLE;
         ilkCnt_q <= '0;
         firstIs0_q <= 1'b0;
      end else begin
         ilk_q <= ilk_d;
         if (timerRestart) ilkCnt_q <= '0;
         else if (ms && ilkCnt_q != CLR) ilkCnt_q <= ilkCnt_q + W'(1);
         if (ilk_q == pulse_monitor_pkg::ILK_IDLE) firstIs0_q <= !in0;
      end
   end

   // Alert and output permission
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         interlockAlert <= 1'b0;
         outputsPermit <= 1'b0;
      end else begin
         interlockAlert <= (ilk_d == pulse_monitor_pkg::ILK_ALERT);
         outputsPermit <= (&actv) && !faultEvt && !crossFault
            && (ilk_d != pulse_monitor_pkg::ILK_ALERT);
      end
   end
   assign msTickOut = ms;

   // Cycle counters on slot 0 for the width and period checks
   logic [31:0] pulseLen_q, periodCnt_q;
   logic pulsePrev_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseLen_q <= 32'h0;
         periodCnt_q <= 32'h0;
         pulsePrev_q <= 1'b1;
      end else begin
         pulseLen_q <= pulseOn[0] ? pulseLen_q + 32'h1 : 32'h0;
         periodCnt_q <= (pulseOn[0] && !pulsePrev_q) ? 32'h1 : periodCnt_q + 32'h1;
         pulsePrev_q <= pulseOn[0];
      end
   end

   // Assertions
   sequence s_drop0;
      !in0 && in1;
   endsequence
   sequence s_both_off;
      !in0 && !in1;
   endsequence
   property p_pulse_gap;
      @(posedge core_clk) disable iff (!rst_n)
         $fell(pulseOn[0]) |-> !pulseOn[0] [*8];
   endproperty
   a_pulse_gap: assert property (p_pulse_gap) else $error("pulse retriggered");
   property p_pulse_dis;
      @(posedge core_clk) disable iff (!rst_n)
         !pulseTestEn |-> ##1 (&supplyOut) && startSupplyOut;
   endproperty
   a_pulse_dis: assert property (p_pulse_dis) else $error("pulse while disabled");
   property p_phase;
      @(posedge core_clk) disable iff (!rst_n)
         $onehot0(pulseOn);
   endproperty
   a_phase: assert property (p_phase) else $error("pulses overlap");
   property p_win_exp;
      @(posedge core_clk) disable iff (!rst_n)
         (ilk_q == pulse_monitor_pkg::ILK_WINDOW && !bothOff && !firstBack && winExp)
         |=> interlockAlert;
   endproperty
   a_win_exp: assert property (p_win_exp) else $error("no alert at window end");
   property p_reopen;
      @(posedge core_clk) disable iff (!rst_n)
         (ilk_q == pulse_monitor_pkg::ILK_WINDOW && !bothOff && firstBack) |=> interlockAlert;
   endproperty
   a_reopen: assert property (p_reopen) else $error("no immediate alert");
   property p_alert_block;
      @(posedge core_clk) disable iff (!rst_n)
         interlockAlert |-> !outputsPermit;
   endproperty
   a_alert_block: assert property (p_alert_block) else $error("outputs with alert");
   property p_deact;
      @(posedge core_clk) disable iff (!rst_n)
         !(&actv) |=> !outputsPermit;
   endproperty
   a_deact: assert property (p_deact) else $error("outputs while deactivated");
   property p_fault;
      @(posedge core_clk) disable iff (!rst_n)
         faultEvt |=> crossFault && !outputsPermit;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not flagged");
   property p_ilk_off;
      @(posedge core_clk) disable iff (!rst_n)
         !interlockEn |=> !interlockAlert;
   endproperty
   a_ilk_off: assert property (p_ilk_off) else $error("alert while disabled");
   property p_clear;
      @(posedge core_clk) disable iff (!rst_n)
         (interlockAlert && $rose(bothOff)) |=> interlockAlert [*2];
   endproperty
   a_clear: assert property (p_clear) else $error("alert cleared early");
   property p_window_start;
      @(posedge core_clk) disable iff (!rst_n)
         (ilk_q == pulse_monitor_pkg::ILK_IDLE && interlockEn) ##0 s_drop0
         |=> ilk_q == pulse_monitor_pkg::ILK_WINDOW;
   endproperty
   a_window_start: assert property (p_window_start) else $error("window not opened");
   property p_pulse_width;
      @(posedge core_clk) disable iff (!rst_n)
         $fell(pulseOn[0]) && pulseTestEn |-> pulseLen_q == DUR_CYC;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
   property p_pulse_period;
      @(posedge core_clk) disable iff (!rst_n)
         $rose(pulseOn[0]) && pulseTestEn |-> periodCnt_q == INT_CYC;
   endproperty
   a_pulse_period: assert property (p_pulse_period) else $error("pulse period wrong");
   property p_both_ok;
      @(posedge core_clk) disable iff (!rst_n)
         (ilk_q == pulse_monitor_pkg::ILK_WINDOW && interlockEn) ##0 s_both_off
         |=> !interlockAlert;
   endproperty
   a_both_ok: assert property (p_both_ok) else $error("alert despite joint drop");
   property p_clear_done;
      @(posedge core_clk) disable iff (!rst_n)
         (ilk_q == pulse_monitor_pkg::ILK_ALERT && interlockEn && clrDone) ##0 s_both_off
         |=> !interlockAlert;
   endproperty
   a_clear_done: assert property (p_clear_done) else $error("alert not cleared");
endmodule

// ---- testbench/sensor_model.sv ----
// Behavioural sensors, switches and start button on the supply loops
`timescale 1ns/1ps
module sensor_model (
   input wire logic [5:0] supplyOut,
   input wire logic startSupplyOut,
   input wire logic [5:0] stuckMask,
   input wire logic crossEn,
   output logic [5:0] channelAIn,
   output logic [5:0] channelBIn,
   output logic startSenseIn
);
   // Closed contacts return each supply; a stuck contact is shorted to external supply
   assign channelAIn = supplyOut | stuckMask;
   // Optional short of input 1 channel B onto the supply of input 0
   assign channelBIn = {supplyOut[5:2], supplyOut[1] & (supplyOut[0] | !crossEn), supplyOut[0]};
   // Start push-button held closed
   assign startSenseIn = startSupplyOut;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the pulse and interlock monitor
`timescale 1ns/1ps
module testbench;
   localparam int CPM = 4;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pulseTestEn = 1'b1;
   logic interlockEn = 1'b0;
   logic [5:0] inputActive = 6'h3F;
   logic [5:0] stuckMask = 6'h00;
   logic crossEn = 1'b0;
   logic [5:0] channelAIn, channelBIn, supplyOut;
   logic startSenseIn, startSupplyOut, crossFault, interlockAlert, outputsPermit, msTickOut;
   int nTick = 0;
   logic [6:0] supPrev = 7'h00;
   wire logic [6:0] sup = {startSupplyOut, supplyOut};
   int cyc = 0;
   int fallAt [7];
   int lowLen [7];
   int period [7];
   int n_mismatch = 0;
   int num_checks = 0;

   input_test_pulse_interlock_monitor #(.CYCLES_PER_MS(CPM)) u_input_test_pulse_interlock_monitor (
      .core_clk(core_clk), .rst_n(rst_n), .pulseTestEn(pulseTestEn),
      .interlockEn(interlockEn), .channelAIn(channelAIn), .channelBIn(channelBIn),
      .startSenseIn(startSenseIn), .inputActive(inputActive), .supplyOut(supplyOut),
      .startSupplyOut(startSupplyOut), .crossFault(crossFault),
      .interlockAlert(interlockAlert), .outputsPermit(outputsPermit), .msTickOut(msTickOut));
   sensor_model u_sensor_model (
      .supplyOut(supplyOut), .startSupplyOut(startSupplyOut), .stuckMask(stuckMask),
      .crossEn(crossEn), .channelAIn(channelAIn), .channelBIn(channelBIn),
      .startSenseIn(startSenseIn));

   // Clock
   always #2 core_clk = ~core_clk;

   // Fall time, low width and period of every supply
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      supPrev <= sup;
      if (msTickOut) nTick <= nTick + 1;
      for (int g = 0; g < 7; g++) begin
         if (supPrev[g] && !sup[g]) begin
            period[g] <= cyc - fallAt[g];
            fallAt[g] <= cyc;
         end
         if (!supPrev[g] && sup[g]) lowLen[g] <= cyc - fallAt[g];
      end
   end

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic ms(int n);
      tick(n * CPM);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      ms(5);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic t_pulses();
      int t0;
      do_reset();
      t0 = nTick;
      ms(2100);
      chk("msTicks", 2100, nTick - t0);
      for (int g = 0; g < 7; g++) begin
         chk("pulseWidth", 2 * CPM, lowLen[g]);
         chk("pulsePeriod", 1000 * CPM, period[g]);
      end
      for (int g = 1; g < 7; g++) begin
         chk("pulsePhase", 70 * CPM, (fallAt[g] - fallAt[g-1] + 4000 * CPM) % (1000 * CPM));
      end
      chk("crossFault", 0, crossFault);
      chk("outputsPermit", 1, outputsPermit);
   endtask
   task automatic t_disabled();
      pulseTestEn = 1'b0;
      stuckMask = 6'h3F;
      do_reset();
      ms(1100);
      chk("supplies", 7'h7F, sup);
      chk("crossFault", 0, crossFault);
      pulseTestEn = 1'b1;
      stuckMask = 6'h00;
   endtask
   task automatic t_faults();
      stuckMask = 6'h08;
      do_reset();
      ms(300);
      stuckMask = 6'h00;
      ms(5);
      chk("crossFault", 1, crossFault);
      chk("outputsPermit", 0, outputsPermit);
      crossEn = 1'b1;
      do_reset();
      ms(100);
      chk("crossFault", 1, crossFault);
      crossEn = 1'b0;
   endtask
   task automatic t_ilk_ok();
      interlockEn = 1'b1;
      do_reset();
      inputActive = 6'h3E;
      ms(1);
      chk("outputsPermit", 0, outputsPermit);
      ms(100);
      inputActive = 6'h3C;
      ms(300);
      chk("interlockAlert", 0, interlockAlert);
      inputActive = 6'h3F;
      ms(2);
      chk("outputsPermit", 1, outputsPermit);
   endtask
   task automatic t_ilk_late();
      inputActive = 6'h3E;
      ms(190);
      chk("interlockAlert", 0, interlockAlert);
      ms(15);
      chk("interlockAlert", 1, interlockAlert);
      inputActive = 6'h3C;
      ms(990);
      chk("interlockAlert", 1, interlockAlert);
      ms(15);
      chk("interlockAlert", 0, interlockAlert);
      inputActive = 6'h3F;
      ms(2);
      chk("outputsPermit", 1, outputsPermit);
   endtask
   task automatic t_ilk_back();
      inputActive = 6'h3E;
      ms(50);
      inputActive = 6'h3F;
      tick(5);
      chk("interlockAlert", 1, interlockAlert);
      inputActive = 6'h3C;
      ms(1005);
      chk("interlockAlert", 0, interlockAlert);
      inputActive = 6'h3F;
      interlockEn = 1'b0;
      do_reset();
      inputActive = 6'h3E;
      ms(300);
      chk("interlockAlert", 0, interlockAlert);
   endtask

   // Watchdog
   initial begin
      #160000;
      n_mismatch++;
      end_of_test();
   end
   // Main sequence
   initial begin
      t_pulses();
      t_disabled();
      t_faults();
      t_ilk_ok();
      t_ilk_late();
      t_ilk_back();
      end_of_test();
   end
endmodule
